// >>> hdl/fieldbus_output_fault_guard.sv
// output supervision and master bus timing of the fieldbus gateway
`timescale 1ns/1ps
`include "fault_guard_consts.svh"
module fieldbus_output_fault_guard
	import fault_guard_pkg::*;
#(
	parameter int NUM_MODULES = 4,
	parameter int NUM_BYTES   = 4,
	parameter int MS_CYC      = `MS_TICK_CYC,
	parameter int SLOT_CYC    = `SLOT_TICK_CYC
)
(
	input  wire logic                             CLK_I,
	input  wire logic                             RESETN_I,
	input  wire logic [NUM_MODULES*16-1:0]        CFG_TIMEOUT_I,
	input  wire logic [NUM_MODULES*NUM_BYTES*8-1:0] CFG_FAULT_VALUE_I,
	input  wire logic [15:0]                      CFG_SLOT_I,
	input  wire logic [23:0]                      CFG_TARGET_ROTATION_TIME_I,
	input  wire logic [7:0]                       CFG_GAP_MAINTENANCE_INTERVAL_I,
	input  wire logic [6:0]                       CFG_HIGHEST_STATION_LIMIT_I,
	input  wire logic [3:0]                       CFG_RETRY_LIMIT_I,
	input  wire logic [15:0]                      CFG_WATCHDOG_I,
	input  wire logic                             SAVE_I,
	input  wire logic [NUM_MODULES-1:0]           MEM_ACCESS_I,
	input  wire logic [NUM_MODULES*NUM_BYTES*8-1:0] MEM_DATA_I,
	input  wire logic                             REQ_SENT_I,
	input  wire logic                             RESP_RCVD_I,
	input  wire logic                             TOKEN_ROUND_I,
	input  wire logic [6:0]                       STATION_ADDR_I,
	output logic      [NUM_MODULES*NUM_BYTES*8-1:0] OUT_DATA_O,
	output logic      [NUM_MODULES-1:0]           FAULT_O,
	output logic                                  RETRY_O,
	output logic                                  TXN_FAIL_O,
	output logic                                  TXN_DONE_O,
	output logic                                  GAP_CYCLE_O,
	output logic                                  ROTATION_OVERRUN_O,
	output logic                                  ADDR_VALID_O,
	output logic      [15:0]                      WATCHDOG_PARAM_O,
	output logic                                  REBOOT_REQ_O
);
	localparam int NB = NUM_MODULES * NUM_BYTES; // total output bytes

	// ************************************************************
	// configuration captured once after reset release
	// ************************************************************
	logic        loaded_reg;                   // capture done
	logic [15:0] tmo_reg [NUM_MODULES];        // per-module timeout
	logic [7:0]  fault_val_reg [NB];           // per-byte fault value
	logic [15:0] slot_reg;                     // slot time, 100 us units
	logic [23:0] rot_reg;                      // target rotation, 100 us units
	logic [7:0]  gap_reg;                      // token rounds between gaps
	logic [6:0]  hsa_reg;                      // highest station limit
	logic [3:0]  retry_lim_reg;                // retry limit

	// settings are taken only while loaded_reg is low, so later edits wait for a restart
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			loaded_reg       <= 1'b0;
			slot_reg         <= `SLOT_RST;
			rot_reg          <= `ROT_RST;
			gap_reg          <= `GAP_RST;
			hsa_reg          <= `HSA_RST;
			retry_lim_reg    <= `RETRY_RST;
			WATCHDOG_PARAM_O <= `WDOG_RST;
		end
		else if (!loaded_reg)
		begin
			loaded_reg       <= 1'b1;
			slot_reg         <= CFG_SLOT_I;
			rot_reg          <= CFG_TARGET_ROTATION_TIME_I;
			gap_reg          <= CFG_GAP_MAINTENANCE_INTERVAL_I;
			hsa_reg          <= CFG_HIGHEST_STATION_LIMIT_I;
			retry_lim_reg    <= CFG_RETRY_LIMIT_I;
			WATCHDOG_PARAM_O <= CFG_WATCHDOG_I;
		end
	end

	// saved configuration asks the system to restart
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			REBOOT_REQ_O <= 1'b0;
		else if (SAVE_I)
			REBOOT_REQ_O <= 1'b1;
	end

	// ************************************************************
	// time bases
	// ************************************************************
	logic ms_tick;   // one pulse per millisecond
	logic slot_tick; // one pulse per 100 us

	tick_gen #(.DIV(MS_CYC)) u_ms_tick
	(
		.clk_i  (CLK_I),
		.rstn_i (RESETN_I),
		.tick_o (ms_tick)
	);

	tick_gen #(.DIV(SLOT_CYC)) u_slot_tick
	(
		.clk_i  (CLK_I),
		.rstn_i (RESETN_I),
		.tick_o (slot_tick)
	);

	// ************************************************************
	// per-module supervision and output substitution
	// ************************************************************
	genvar m, b;
	generate
		for (m = 0; m < NUM_MODULES; m++)
		begin : g_mod
			// timeout capture for this module
			always_ff @(posedge CLK_I or negedge RESETN_I)
			begin
				if (!RESETN_I)
					tmo_reg[m] <= `TMO_RST;
				else if (!loaded_reg)
					tmo_reg[m] <= CFG_TIMEOUT_I[m*16 +: 16];
			end

			// each module keeps its own independent timer
			module_supervisor #(.TW(16)) u_sup
			(
				.clk_i     (CLK_I),
				.rstn_i    (RESETN_I),
				.tick_i    (ms_tick),
				.access_i  (MEM_ACCESS_I[m]),
				.timeout_i (tmo_reg[m]),
				.fault_o   (FAULT_O[m])
			);

			for (b = 0; b < NUM_BYTES; b++)
			begin : g_byte
				localparam int IX = m * NUM_BYTES + b;

				// per-byte fault value capture
				always_ff @(posedge CLK_I or negedge RESETN_I)
				begin
					if (!RESETN_I)
						fault_val_reg[IX] <= `BYTE_RST;
					else if (!loaded_reg)
						fault_val_reg[IX] <= CFG_FAULT_VALUE_I[IX*8 +: 8];
				end

				// output byte: fault value while faulted, else memory contents
				// one cycle behind the fault flag, a trade for a registered pin
				always_ff @(posedge CLK_I or negedge RESETN_I)
				begin
					if (!RESETN_I)
						OUT_DATA_O[IX*8 +: 8] <= `BYTE_RST;
					else if (FAULT_O[m])
						OUT_DATA_O[IX*8 +: 8] <= fault_val_reg[IX];
					else
						OUT_DATA_O[IX*8 +: 8] <= MEM_DATA_I[IX*8 +: 8];
				end

				fault_byte_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
					FAULT_O[m] |=> OUT_DATA_O[IX*8 +: 8] == $past(fault_val_reg[IX]))
					else $error("fault value not driven on output byte");
				keep_latest_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
					(tmo_reg[m] == `TMO_RST) |=> OUT_DATA_O[IX*8 +: 8] == $past(MEM_DATA_I[IX*8 +: 8]))
					else $error("zero timeout did not pass latest data");
			end
		end
	endgenerate

	// ************************************************************
	// slot timer and retry control
	// ************************************************************
	txn_state_t  state_reg;     // waiting for a slave answer or not
	logic [15:0] slot_cnt_reg;  // elapsed 100 us units in this attempt
	logic [3:0]  retry_cnt_reg; // retries already made
	logic        slot_expired;  // wait reached slot time

	assign slot_expired = slot_tick && (slot_cnt_reg + 1'b1 >= slot_reg);

	// an answer in the expiry cycle still counts as an answer
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_reg     <= TXN_IDLE;
			slot_cnt_reg  <= '0;
			retry_cnt_reg <= '0;
			RETRY_O       <= 1'b0;
			TXN_FAIL_O    <= 1'b0;
			TXN_DONE_O    <= 1'b0;
		end
		else
		begin
			RETRY_O    <= 1'b0;
			TXN_FAIL_O <= 1'b0;
			TXN_DONE_O <= 1'b0;
			unique case (state_reg)
				TXN_IDLE:
				begin
					// new request opens the wait window
					if (REQ_SENT_I)
					begin
						state_reg     <= TXN_WAIT;
						slot_cnt_reg  <= '0;
						retry_cnt_reg <= '0;
					end
				end
				TXN_WAIT:
				begin
					if (RESP_RCVD_I)
					begin
						state_reg  <= TXN_IDLE;
						TXN_DONE_O <= 1'b1;
					end
					else if (slot_expired)
					begin
						slot_cnt_reg <= '0;
						if (retry_cnt_reg < retry_lim_reg)
						begin
							retry_cnt_reg <= retry_cnt_reg + 1'b1;
							RETRY_O       <= 1'b1;
						end
						else
						begin
							state_reg  <= TXN_IDLE;
							TXN_FAIL_O <= 1'b1;
						end
					end
					else if (slot_tick)
						slot_cnt_reg <= slot_cnt_reg + 1'b1;
				end
			endcase
		end
	end

	slot_bound_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(RETRY_O || TXN_FAIL_O) |-> ($past(state_reg) == TXN_WAIT) && $past(slot_tick)
			&& ($past(slot_cnt_reg) + 1'b1 >= $past(slot_reg)))
		else $error("slot timeout not at slot time");
	retry_cap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		RETRY_O |-> retry_cnt_reg <= retry_lim_reg)
		else $error("retry beyond limit");

	// ************************************************************
	// token rotation and gap maintenance
	// ************************************************************
	logic [7:0]  round_cnt_reg; // token rounds since last gap cycle
	logic [23:0] rot_cnt_reg;   // 100 us units since token arrival

	// gap cycle every configured number of rounds
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			round_cnt_reg <= '0;
			GAP_CYCLE_O   <= 1'b0;
		end
		else if (TOKEN_ROUND_I && (round_cnt_reg + 1'b1 >= gap_reg))
		begin
			round_cnt_reg <= '0;
			GAP_CYCLE_O   <= 1'b1;
		end
		else
		begin
			GAP_CYCLE_O <= 1'b0;
			if (TOKEN_ROUND_I)
				round_cnt_reg <= round_cnt_reg + 1'b1;
		end
	end

	// rotation longer than target is flagged until the next token
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rot_cnt_reg        <= '0;
			ROTATION_OVERRUN_O <= 1'b0;
		end
		else if (TOKEN_ROUND_I)
		begin
			rot_cnt_reg        <= '0;
			ROTATION_OVERRUN_O <= 1'b0;
		end
		else if (slot_tick && rot_cnt_reg < rot_reg)
			rot_cnt_reg <= rot_cnt_reg + 1'b1;
		else if (rot_cnt_reg >= rot_reg)
			ROTATION_OVERRUN_O <= 1'b1;
	end

	// station address check against the highest station limit
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			ADDR_VALID_O <= 1'b0;
		else
			ADDR_VALID_O <= (STATION_ADDR_I <= hsa_reg);
	end

	gap_cause_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		GAP_CYCLE_O |-> $past(TOKEN_ROUND_I) && ($past(round_cnt_reg) + 1'b1 >= $past(gap_reg)))
		else $error("gap cycle without enough rounds");
	addr_limit_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		ADDR_VALID_O |-> $past(STATION_ADDR_I) <= $past(hsa_reg))
		else $error("address above limit accepted");
	cfg_frozen_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		loaded_reg && $past(loaded_reg) |-> $stable(slot_reg) && $stable(retry_lim_reg))
		else $error("settings changed without restart");
endmodule : fieldbus_output_fault_guard

// >>> common/fault_guard_consts.svh
// constants for the fieldbus output fault guard
//
// Summary of operation
// - timeout is zero or 100..60000 ms
// - zero or out-of-range timeout disables supervision
// - expired supervision drives fault values out
// - one fault value per output byte
// - any access restarts timer, even unchanged data
// - zero timeout keeps latest output values
// - slave answer awaited at most slot time
// - target rotation time bounds token circulation
// - gap maintenance after configured token rounds
// - highest station limit caps addresses
// - retries never exceed retry limit
// - watchdog time handed to slaves
// - saved settings act only after restart
`ifndef FAULT_GUARD_CONSTS_SVH
`define FAULT_GUARD_CONSTS_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS   50
`define MS_TIME_NS      1000000
`define SLOT_UNIT_NS    100000
`define MS_TICK_CYC     (`MS_TIME_NS / `CLK_PERIOD_NS)
`define SLOT_TICK_CYC   (`SLOT_UNIT_NS / `CLK_PERIOD_NS)

// ************************************************************
// supervision timeout range in ms
// ************************************************************
`define TMO_MIN_MS      16'h0064
`define TMO_MAX_MS      16'hEA60

// ************************************************************
// reset values of captured configuration
// ************************************************************
`define SLOT_RST        16'h012C
`define ROT_RST         24'h00307B
`define GAP_RST         8'h0A
`define HSA_RST         7'h7E
`define RETRY_RST       4'h1
`define WDOG_RST        16'h0258
`define TMO_RST         16'h0000
`define BYTE_RST        8'h00

`endif

// >>> common/fault_guard_pkg.sv
// types shared by the fieldbus output fault guard
package fault_guard_pkg;
	// request wait state of the master transaction engine
	typedef enum logic [0:0]
	{
		TXN_IDLE = 1'b0,
		TXN_WAIT = 1'b1
	} txn_state_t;
endpackage : fault_guard_pkg

// >>> hdl/tick_gen.sv
// free running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ps
module tick_gen
#(
	parameter int DIV = 20
)
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	output logic      tick_o
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_reg; // position inside the period

	// ************************************************************
	// divider
	// ************************************************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end
		else if (cnt_reg == CW'(DIV - 1))
		begin
			// wrap and fire
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end
endmodule : tick_gen

// >>> hdl/module_supervisor.sv
// inactivity timer of one output module
`timescale 1ns/1ps
`include "fault_guard_consts.svh"
module module_supervisor
#(
	parameter int TW = 16
)
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          tick_i,    // 1 ms step
	input  wire logic          access_i,  // block touched
	input  wire logic [TW-1:0] timeout_i, // captured timeout in ms
	output logic               fault_o
);
	logic [TW-1:0] cnt_reg;  // elapsed ms since last access
	logic [TW-1:0] cnt_next; // one more ms
	logic          enabled;  // timeout inside valid range

	// out-of-range values are simply treated as off
	assign enabled  = (timeout_i >= `TMO_MIN_MS) && (timeout_i <= `TMO_MAX_MS);
	assign cnt_next = cnt_reg + 1'b1;

	// ************************************************************
	// timer and fault flag
	// ************************************************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_reg <= '0;
			fault_o <= 1'b0;
		end
		else if (access_i)
		begin
			// access wins over an expiry in the same cycle
			cnt_reg <= '0;
			fault_o <= 1'b0;
		end
		else if (!enabled)
		begin
			cnt_reg <= '0;
			fault_o <= 1'b0;
		end
		else if (tick_i && !fault_o)
		begin
			if (cnt_next == timeout_i)
				fault_o <= 1'b1;
			else
				cnt_reg <= cnt_next;
		end
	end

	access_clears_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		access_i |=> !fault_o && (cnt_reg == '0))
		else $error("access did not restart timer");
	off_no_fault_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!enabled |=> !fault_o)
		else $error("fault raised while supervision off");
	expiry_cause_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(fault_o) |-> $past(enabled) && $past(tick_i)
			&& ($past(cnt_reg) == $past(timeout_i) - 1'b1))
		else $error("fault raised before full timeout");
endmodule : module_supervisor

// >>> tb/fieldbus_slave_model.sv
// behavioural fieldbus slave that answers master requests
`timescale 1ns/1ps
module fieldbus_slave_model
#(
	parameter int MIN_DLY = 11,  // shortest reply delay in bit times
	parameter int MAX_DLY = 255, // longest reply delay in bit times
	parameter int QUIET   = 0    // quiet bit times after a frame
)
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       req_i,      // request seen on the bus
	input  wire logic       mute_i,     // slave gone silent
	input  wire logic [7:0] dly_i,      // wanted delay, one bit time per clock
	input  wire logic       sync_i,     // sync command pulse
	input  wire logic       unsync_i,   // unsync command pulse
	input  wire logic       freeze_i,   // freeze command pulse
	input  wire logic [7:0] out_i,      // output byte sent by the master
	input  wire logic [7:0] in_i,       // local input sample
	output logic            resp_o,     // one-cycle answer
	output logic      [7:0] applied_o,  // output byte driving the process
	output logic      [7:0] reported_o  // input byte returned to the master
);
	// ************************************************************
	// reply timer
	// ************************************************************
	int         cnt_reg;   // bit times left until the answer, 0 = idle
	int         quiet_reg; // bit times with the receiver still off
	logic       sync_reg;  // outputs held by sync
	logic       frz_reg;   // inputs held by freeze
	logic [7:0] prev_reg;  // output byte of the last cycle
	logic [7:0] buf_reg;   // newer input sample, not transferred

	// receiver stays off for the quiet time after our own frame
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			quiet_reg <= 0;
		else if (cnt_reg == 1)
			quiet_reg <= QUIET;
		else if (quiet_reg > 0)
			quiet_reg <= quiet_reg - 1;
	end

	// delay clamped so a careless bench never breaks slave timing
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_reg <= 0;
			resp_o  <= 1'b0;
		end
		else
		begin
			resp_o <= (cnt_reg == 1);  // answer leaves in its own cycle
			if (cnt_reg > 0)
				cnt_reg <= cnt_reg - 1;
			else if (req_i && !mute_i && quiet_reg == 0)
				cnt_reg <= (dly_i < MIN_DLY) ? MIN_DLY :
					((dly_i > MAX_DLY) ? MAX_DLY : int'(dly_i));
		end
	end

	// ************************************************************
	// sync and freeze holding
	// ************************************************************
	// sync applies the previous output, newer data waits for the next command
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync_reg  <= 1'b0;
			prev_reg  <= 8'h00;
			applied_o <= 8'h00;
		end
		else
		begin
			prev_reg <= out_i;
			if (unsync_i)
				sync_reg <= 1'b0;
			else if (sync_i)
				sync_reg <= 1'b1;
			if (unsync_i || (!sync_reg && !sync_i))
				applied_o <= out_i;    // free running
			else if (sync_i)
				applied_o <= prev_reg;
		end
	end

	// freeze returns the last input, newer samples only fill the buffer
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			frz_reg    <= 1'b0;
			buf_reg    <= 8'h00;
			reported_o <= 8'h00;
		end
		else if (freeze_i)
		begin
			frz_reg    <= 1'b1;
			reported_o <= frz_reg ? buf_reg : in_i;
		end
		else if (frz_reg)
			buf_reg <= in_i;
		else
			reported_o <= in_i;
	end
endmodule : fieldbus_slave_model

// >>> tb/fieldbus_output_fault_guard_test.sv
// self-checking bench of the fieldbus output fault guard
`timescale 1ns/1ps
`include "fault_guard_consts.svh"
module fieldbus_output_fault_guard_test;
	// ************************************************************
	// signals
	// ************************************************************
	localparam int NM = 4;        // output modules
	localparam int NB = 2;        // bytes per module
	localparam int DW = NM*NB*8;  // all output bytes
	logic          clk, rst_n, save, req, resp, tok, mute;
	logic          sync, unsync, frz;
	logic          retry, fail, done, gapc, ovr, aval, reboot;
	logic [NM*16-1:0] tmo;        // per-module timeouts
	logic [DW-1:0] fval, mem, out;
	logic [NM-1:0] acc, flt;
	logic [15:0]   slot, wdog, wpar;
	logic [23:0]   rot;
	logic [7:0]    gap, dly, smp, app, rep;
	logic [6:0]    highest_station_limit, addr;
	logic [3:0]    rty;
	int            seed = 32'hAF3B6368;
	int            bad_count, check_count, n, r, f, t1;

	fieldbus_output_fault_guard #(.NUM_MODULES(NM), .NUM_BYTES(NB), .MS_CYC(20),
		.SLOT_CYC(10)) u_dut (.CLK_I(clk), .RESETN_I(rst_n), .CFG_TIMEOUT_I(tmo),
		.CFG_FAULT_VALUE_I(fval), .CFG_SLOT_I(slot), .CFG_TARGET_ROTATION_TIME_I(rot),
		.CFG_GAP_MAINTENANCE_INTERVAL_I(gap), .CFG_HIGHEST_STATION_LIMIT_I(highest_station_limit),
		.CFG_RETRY_LIMIT_I(rty), .CFG_WATCHDOG_I(wdog), .SAVE_I(save),
		.MEM_ACCESS_I(acc), .MEM_DATA_I(mem), .REQ_SENT_I(req), .RESP_RCVD_I(resp),
		.TOKEN_ROUND_I(tok), .STATION_ADDR_I(addr), .OUT_DATA_O(out), .FAULT_O(flt),
		.RETRY_O(retry), .TXN_FAIL_O(fail), .TXN_DONE_O(done), .GAP_CYCLE_O(gapc),
		.ROTATION_OVERRUN_O(ovr), .ADDR_VALID_O(aval), .WATCHDOG_PARAM_O(wpar),
		.REBOOT_REQ_O(reboot));
	fieldbus_slave_model #(.QUIET(2)) u_slave (.clk_i(clk), .rstn_i(rst_n), .req_i(req),
		.mute_i(mute), .dly_i(dly), .sync_i(sync), .unsync_i(unsync), .freeze_i(frz),
		.out_i(out[39:32]), .in_i(smp), .resp_o(resp), .applied_o(app),
		.reported_o(rep));

	// ************************************************************
	// helpers
	// ************************************************************
	always #25 clk = ~clk;  // 20 MHz
	// inputs always move 1 ns after the edge
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	task automatic cmp_vec(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_vec
	// faulted modules show their fault bytes, others the memory bytes
	function automatic logic [DW-1:0] exp_out(input logic [NM-1:0] fm);
		logic [DW-1:0] v;
		for (int m = 0; m < NM; m++)
			v[m*NB*8 +: NB*8] = fm[m] ? fval[m*NB*8 +: NB*8] : mem[m*NB*8 +: NB*8];
		return v;
	endfunction : exp_out
	task automatic conclude;
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// hang guard, well beyond the ~5000 cycles the tests take
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		clk = 1'b0; rst_n = 1'b0; save = 1'b0; req = 1'b0; tok = 1'b0; mute = 1'b0;
		acc = '0; addr = 7'h00; dly = 8'h0B;
		sync = 1'b0; unsync = 1'b0; frz = 1'b0;
		tmo = {16'h0096, 16'hEA61, 16'h0000, 16'h0064};  // 150, out of range, 0, 100
		fval = {$random(seed), $random(seed)};
		mem = {$random(seed), $random(seed)};
		slot = 16'h001E;
		rot = 24'h000005;
		gap = 8'h03;
		highest_station_limit = 7'h01 + 7'($unsigned($random(seed)) % 125);
		rty = 4'h1 + 4'($unsigned($random(seed)) % 3);
		wdog = 16'($random(seed));
		smp = 8'($random(seed));
		repeat (8) @(posedge clk);
		cmp_vec("wdog_rst", `WDOG_RST, wpar);
		#1;
		rst_n = 1'b1;
		step(2);
		cmp_vec("wdog_param", wdog, wpar);
		// supervision: module 0 expires first, 1 and 2 never
		acc = '1;
		step(1);
		acc = '0;
		step(1980);
		cmp_vec("fault_early", 0, flt);
		cmp_vec("out_live", exp_out(4'b0000), out);
		step(22);
		cmp_vec("fault_m0", 4'b0001, flt);
		step(1);
		cmp_vec("out_m0", exp_out(4'b0001), out);
		mem = {$random(seed), $random(seed)};
		step(2);
		cmp_vec("out_hold", exp_out(4'b0001), out);
		// refresh with unchanged contents still restarts the timer
		acc = 4'b0001;  // periodic refresh
		step(1);
		acc = '0;
		cmp_vec("fault_clr", 0, flt);
		step(1);
		cmp_vec("out_back", exp_out(4'b0000), out);
		step(1000);
		cmp_vec("fault_m3", 4'b1000, flt);
		step(1);
		cmp_vec("out_m3", exp_out(4'b1000), out);
		// answered transactions at both delay corners and a random one
		for (int i = 0; i < 3; i++)
		begin
			dly = (i == 0) ? 8'h0B : ((i == 1) ? 8'hFF : 8'h0B + 8'($unsigned($random(seed)) % 200));
			req = 1'b1;
			step(1);
			req = 1'b0;
			n = 0;
			r = 0;
			while (resp !== 1'b1 && n < 400)
			begin
				step(1);
				n++;
				r += (retry === 1'b1);
			end
			step(1);
			cmp_bit("txn_done", 1'b1, done);
			cmp_vec("early_retry", 0, r);
			step(3);
		end
		// silent slave: limited retries, then failure
		mute = 1'b1;
		req = 1'b1;
		step(1);
		req = 1'b0;
		r = 0;
		f = 0;
		t1 = 0;
		for (n = 1; n <= 1400; n++)
		begin
			step(1);
			req = (n == 100);  // request while waiting must be ignored
			if (retry === 1'b1 && t1 == 0)
				t1 = n;
			r += (retry === 1'b1);
			f += (fail === 1'b1);
		end
		mute = 1'b0;
		cmp_bit("slot_wait", 1'b1, t1 >= 290 && t1 <= 303);
		cmp_vec("retry_cnt", rty, r);
		cmp_vec("fail_cnt", 1, f);
		// gap maintenance every third round
		r = 0;
		repeat (6)
		begin
			tok = 1'b1;
			step(1);
			tok = 1'b0;
			r += (gapc === 1'b1);
			step(1);
			r += (gapc === 1'b1);
		end
		cmp_vec("gap_cnt", 2, r);
		// rotation overrun of a 500 us target
		tok = 1'b1;
		step(1);
		tok = 1'b0;
		step(30);
		cmp_bit("rot_early", 1'b0, ovr);
		step(70);
		cmp_bit("rot_over", 1'b1, ovr);
		tok = 1'b1;
		step(1);
		tok = 1'b0;
		step(1);
		cmp_bit("rot_clr", 1'b0, ovr);
		// address limit boundary
		addr = highest_station_limit;
		step(2);
		cmp_bit("addr_top", 1'b1, aval);
		addr = highest_station_limit + 7'h01;  // distinct station address
		step(2);
		cmp_bit("addr_over", 1'b0, aval);
		// slave-side sync and freeze on a byte of module 2, one of the two unsupervised modules
		t1 = out[39:32];
		sync = 1'b1;
		step(1);
		sync = 1'b0;
		mem = {$random(seed), $random(seed)};
		step(3);
		cmp_vec("sync_hold", t1, app);
		unsync = 1'b1;
		step(1);
		unsync = 1'b0;
		step(1);
		cmp_vec("unsync_pass", out[39:32], app);
		frz = 1'b1;
		step(1);
		frz = 1'b0;
		t1 = smp;
		smp = 8'($random(seed));
		step(2);
		cmp_vec("freeze_hold", t1, rep);
		// save then restart
		save = 1'b1;
		step(1);
		save = 1'b0;
		step(3);
		cmp_bit("reboot", 1'b1, reboot);
		rst_n = 1'b0;
		step(1);
		cmp_bit("reboot_rst", 1'b0, reboot);
		cmp_vec("wdog_rst2", `WDOG_RST, wpar);
		conclude();
	end
endmodule : fieldbus_output_fault_guard_test
